// [include/rsu_pkg.sv]
// rotate unit package: operation codes and reset values
package rsu_pkg;
    // ----------------------------------------------------------------
    // operation select from the decoder
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RSU_OP_NONE                = 3'h0,
        RSU_OP_ROT_LEFT_MEM        = 3'h1,
        RSU_OP_ROT_LEFT_CARRY_MEM  = 3'h2,
        RSU_OP_ROT_LEFT_CARRY_ACC  = 3'h3,
        RSU_OP_ROT_RIGHT_MEM       = 3'h4,
        RSU_OP_ROT_RIGHT_ACC       = 3'h5,
        RSU_OP_ROT_RIGHT_CARRY_MEM = 3'h6,
        RSU_OP_ROT_RIGHT_CARRY_ACC = 3'h7
    } rsu_op_e;

    // ----------------------------------------------------------------
    // reset values and operand bit positions
    // ----------------------------------------------------------------
    localparam logic [7:0] RSU_DATA_RST  = 8'h00;
    localparam logic       RSU_CARRY_RST = 1'b0;
    localparam int         RSU_MSB       = 7;
    localparam int         RSU_LSB       = 0;
endpackage

// [rtl/rsu_rotate_unit.sv]
// rotate unit: seven single-bit rotates on a data memory operand
`timescale 1ns/1ps

module rsu_rotate_unit (
    input  wire logic                  clk,          // core instruction clock
    input  wire logic                  rst_n,        // async reset, active low
    input  wire rsu_pkg::rsu_op_e      op_sel,       // operation select, one per cycle
    input  wire logic [7:0]            mem_rdata,    // operand from data memory
    input  wire logic                  carry_wr,     // other logic loads carry
    input  wire logic                  carry_wdata,  // value for that load
    output logic [7:0]                 mem_wdata,    // result to data memory
    output logic                       mem_we,       // memory write pulse
    output logic [7:0]                 acc_wdata,    // result to accumulator
    output logic                       acc_we,       // accumulator write pulse
    output logic                       carry_flag    // carry flag
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] mem_wdata_ff;
    logic [7:0] nxt_mem_wdata;
    logic       mem_we_ff;
    logic       nxt_mem_we;
    logic [7:0] acc_wdata_ff;
    logic [7:0] nxt_acc_wdata;
    logic       acc_we_ff;
    logic       nxt_acc_we;
    logic       carry_ff;
    logic       nxt_carry;

    // ----------------------------------------------------------------
    // decoded operation
    // ----------------------------------------------------------------
    logic       op_left;          // rotate towards bit 7
    logic       op_thru;          // carry sits inside the loop
    logic       op_to_mem;        // result goes back to memory
    logic       op_to_acc;        // result goes to the accumulator
    logic       fill_left;        // bit entering at bit 0
    logic       fill_right;       // bit entering at bit 7
    logic [7:0] rot_left;         // operand rotated left
    logic [7:0] rot_right;        // operand rotated right
    logic       out_left;         // bit pushed out at bit 7
    logic       out_right;        // bit pushed out at bit 0
    logic [7:0] rot_res;          // result of the selected direction

    always_comb begin
        op_left   = 1'b0;
        op_thru   = 1'b0;
        op_to_mem = 1'b0;
        op_to_acc = 1'b0;
        case (op_sel)
            rsu_pkg::RSU_OP_ROT_LEFT_MEM: begin
                op_left   = 1'b1;
                op_to_mem = 1'b1;
            end
            rsu_pkg::RSU_OP_ROT_LEFT_CARRY_MEM: begin
                op_left   = 1'b1;
                op_thru   = 1'b1;
                op_to_mem = 1'b1;
            end
            rsu_pkg::RSU_OP_ROT_LEFT_CARRY_ACC: begin
                op_left   = 1'b1;
                op_thru   = 1'b1;
                op_to_acc = 1'b1;
            end
            rsu_pkg::RSU_OP_ROT_RIGHT_MEM: begin
                op_to_mem = 1'b1;
            end
            rsu_pkg::RSU_OP_ROT_RIGHT_ACC: begin
                op_to_acc = 1'b1;
            end
            rsu_pkg::RSU_OP_ROT_RIGHT_CARRY_MEM: begin
                op_thru   = 1'b1;
                op_to_mem = 1'b1;
            end
            rsu_pkg::RSU_OP_ROT_RIGHT_CARRY_ACC: begin
                op_thru   = 1'b1;
                op_to_acc = 1'b1;
            end
            default: begin
                op_left   = 1'b0;
                op_thru   = 1'b0;
                op_to_mem = 1'b0;
                op_to_acc = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // rotate datapath
    // ----------------------------------------------------------------
    // both directions are always computed; a late mux keeps decode off the data path
    always_comb begin
        fill_left  = mem_rdata[rsu_pkg::RSU_MSB];
        fill_right = mem_rdata[rsu_pkg::RSU_LSB];
        if (op_thru) begin
            fill_left  = carry_ff;
            fill_right = carry_ff;
        end
    end

    rsu_rot1 #(
        .WIDTH  (8),
        .TO_MSB (1'b1)
    ) u_rot_left (
        .din    (mem_rdata),
        .fill   (fill_left),
        .dout   (rot_left),
        .lost   (out_left)
    );

    rsu_rot1 #(
        .WIDTH  (8),
        .TO_MSB (1'b0)
    ) u_rot_right (
        .din    (mem_rdata),
        .fill   (fill_right),
        .dout   (rot_right),
        .lost   (out_right)
    );

    always_comb begin
        rot_res = rot_right;
        if (op_left) begin
            rot_res = rot_left;
        end
    end

    // ----------------------------------------------------------------
    // memory result
    // ----------------------------------------------------------------
    // data held when idle to cut toggling on the memory bus
    always_comb begin
        nxt_mem_we    = op_to_mem;
        nxt_mem_wdata = mem_wdata_ff;
        if (op_to_mem) begin
            nxt_mem_wdata = rot_res;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wdata_ff <= rsu_pkg::RSU_DATA_RST;
            mem_we_ff    <= 1'b0;
        end else begin
            mem_wdata_ff <= nxt_mem_wdata;
            mem_we_ff    <= nxt_mem_we;
        end
    end

    // ----------------------------------------------------------------
    // accumulator result
    // ----------------------------------------------------------------
    // accumulator forms never raise the memory strobe
    always_comb begin
        nxt_acc_we    = op_to_acc;
        nxt_acc_wdata = acc_wdata_ff;
        if (op_to_acc) begin
            nxt_acc_wdata = rot_res;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_wdata_ff <= rsu_pkg::RSU_DATA_RST;
            acc_we_ff    <= 1'b0;
        end else begin
            acc_wdata_ff <= nxt_acc_wdata;
            acc_we_ff    <= nxt_acc_we;
        end
    end

    // ----------------------------------------------------------------
    // carry flag
    // ----------------------------------------------------------------
    // a carry rotate wins over an outside load in the same cycle
    always_comb begin
        nxt_carry = carry_ff;
        if (op_thru) begin
            if (op_left) begin
                nxt_carry = out_left;
            end else begin
                nxt_carry = out_right;
            end
        end else if (carry_wr) begin
            nxt_carry = carry_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_ff <= rsu_pkg::RSU_CARRY_RST;
        end else begin
            carry_ff <= nxt_carry;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign mem_wdata  = mem_wdata_ff;
    assign mem_we     = mem_we_ff;
    assign acc_wdata  = acc_wdata_ff;
    assign acc_we     = acc_we_ff;
    assign carry_flag = carry_ff;
endmodule

// ----------------------------------------------------------------
// single-bit rotate slice
// ----------------------------------------------------------------
// the bit pushed out is reported so the caller can load it into carry
module rsu_rot1 #(
    parameter int   WIDTH  = 8,      // operand width
    parameter logic TO_MSB = 1'b1    // travel towards the top bit
) (
    input  wire logic [WIDTH-1:0] din,    // operand
    input  wire logic             fill,   // bit entering the vacated end
    output logic      [WIDTH-1:0] dout,   // rotated operand
    output logic                  lost    // bit leaving the far end
);
    always_comb begin
        if (TO_MSB) begin
            dout = {din[WIDTH-2:0], fill};
            lost = din[WIDTH-1];
        end else begin
            dout = {fill, din[WIDTH-1:1]};
            lost = din[0];
        end
    end
endmodule

// [dv/rsu_rotate_unit_asserts.sv]
// concurrent checks for the rotate unit
`timescale 1ns/1ps
module rsu_rotate_unit_asserts (
    input wire logic clk, rst_n, carry_wr, carry_wdata, mem_we, acc_we, carry_flag,
    input wire rsu_pkg::rsu_op_e op_sel,
    input wire logic [7:0] mem_rdata, mem_wdata, acc_wdata
);
    logic [7:0] d_ff;
    logic       c_ff;
    // operand and carry as they stood when the op was taken
    always_ff @(posedge clk) begin
        d_ff <= mem_rdata;
        c_ff <= carry_flag;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_op_idle; op_sel != 3'h0 ##1 op_sel == 3'h0; endsequence
    lm_wrap_a: assert property (op_sel == 3'h1 && !carry_wr |=> mem_we &&
        mem_wdata == {d_ff[6:0], d_ff[7]} && carry_flag == c_ff) else $error("bad lm");
    lcm_loop_a: assert property (op_sel == 3'h2 |=> mem_we &&
        mem_wdata == {d_ff[6:0], c_ff} && carry_flag == d_ff[7]) else $error("bad lcm");
    lca_acc_a: assert property (op_sel == 3'h3 |=> acc_we && !mem_we &&
        acc_wdata == {d_ff[6:0], c_ff} && carry_flag == d_ff[7]) else $error("bad lca");
    rm_wrap_a: assert property (op_sel == 3'h4 && !carry_wr |=> mem_we &&
        mem_wdata == {d_ff[0], d_ff[7:1]} && carry_flag == c_ff) else $error("bad rm");
    ra_acc_a: assert property (op_sel == 3'h5 && !carry_wr |=> acc_we && !mem_we &&
        acc_wdata == {d_ff[0], d_ff[7:1]} && carry_flag == c_ff) else $error("bad ra");
    rcm_loop_a: assert property (op_sel == 3'h6 |=> mem_we &&
        mem_wdata == {c_ff, d_ff[7:1]} && carry_flag == d_ff[0]) else $error("bad rcm");
    rca_acc_a: assert property (op_sel == 3'h7 |=> acc_we && !mem_we &&
        acc_wdata == {c_ff, d_ff[7:1]} && carry_flag == d_ff[0]) else $error("bad rca");
    one_pulse_a: assert property (s_op_idle |=> !mem_we && !acc_we) else $error("long");
endmodule
bind rsu_rotate_unit rsu_rotate_unit_asserts u_chk (.clk(clk), .rst_n(rst_n), .op_sel(op_sel),
    .mem_rdata(mem_rdata), .carry_wr(carry_wr), .carry_wdata(carry_wdata), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .acc_wdata(acc_wdata), .acc_we(acc_we), .carry_flag(carry_flag));

// [dv/rsu_partner.sv]
// decoder and data memory stand-in: random op and operand each cycle
`timescale 1ns/1ps
module rsu_partner (
    input  wire logic        clk,       // core clock
    input  wire logic        rst_n,     // reset, active low
    output rsu_pkg::rsu_op_e op_sel,    // operation
    output logic [7:0]       mem_rdata  // operand
);
    initial {op_sel, mem_rdata} = '0;
    // no op while reset is low
    always @(negedge clk) begin
        op_sel <= rst_n ? rsu_pkg::rsu_op_e'($urandom_range(7)) : rsu_pkg::RSU_OP_NONE;
        mem_rdata <= 8'($urandom);
    end
endmodule

// [dv/rotate_shift_unit_bench.sv]
// self-checking bench for the rotate unit
`timescale 1ns/1ps
module rotate_shift_unit_bench;
    logic clk, rst_n, carry_wr, carry_wdata, mem_we, acc_we, carry_flag, e_mw, e_aw, e_c;
    logic [7:0] mem_rdata, mem_wdata, acc_wdata, e_md, e_ad, r;
    rsu_pkg::rsu_op_e op_sel;
    int n_mismatch = 0, num_checks = 0;
    rsu_partner u_ptn (.clk(clk), .rst_n(rst_n), .op_sel(op_sel), .mem_rdata(mem_rdata));
    rsu_rotate_unit uut (.clk(clk), .rst_n(rst_n), .op_sel(op_sel), .mem_rdata(mem_rdata),
        .carry_wr(carry_wr), .carry_wdata(carry_wdata), .mem_wdata(mem_wdata), .mem_we(mem_we),
        .acc_wdata(acc_wdata), .acc_we(acc_we), .carry_flag(carry_flag));
    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task end_sim;
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // reference model; op_sel[2:1] picks the rotate kind
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) {e_mw, e_aw, e_c, e_md, e_ad} = '0;
        else begin
            case (op_sel[2:1])
                2'h0: r = {mem_rdata[6:0], mem_rdata[7]};
                2'h1: r = {mem_rdata[6:0], e_c};
                2'h2: r = {mem_rdata[0], mem_rdata[7:1]};
                default: r = {e_c, mem_rdata[7:1]};
            endcase
            e_mw = op_sel inside {3'h1, 3'h2, 3'h4, 3'h6};
            e_aw = op_sel inside {3'h3, 3'h5, 3'h7};
            if (e_mw) e_md = r;
            if (e_aw) e_ad = r;
            if (op_sel inside {3'h2, 3'h3}) e_c = mem_rdata[7];
            else if (op_sel inside {3'h6, 3'h7}) e_c = mem_rdata[0];
            else if (carry_wr) e_c = carry_wdata;
        end
    end
    always @(negedge clk) begin
        chk({5'h0, mem_we, acc_we, carry_flag}, {5'h0, e_mw, e_aw, e_c});
        chk(mem_wdata, e_md);
        chk(acc_wdata, e_ad);
        carry_wr <= ($urandom_range(7) == 0);
        carry_wdata <= 1'($urandom);
    end
    initial begin
        clk = 1'b1;
        forever #5 clk = ~clk;
    end
    initial begin
        void'($urandom(44));
        {rst_n, carry_wr, carry_wdata} = 3'h4;
        {e_mw, e_aw, e_c, e_md, e_ad} = '0;
        #1 rst_n = 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (1000) @(negedge clk);
        #2 rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (1000) @(negedge clk);
        end_sim;
    end
    initial begin
        #40000;
        n_mismatch++;
        end_sim;
    end
endmodule
